// ===== design/psr_controller.sv
// host-side controller for an asynchronous 512k x 8 pseudo static ram
`include "psr_params.svh"
`default_nettype none

// Notes on behaviour
// - auto refresh pulse between 30 ns and 8000 ns
// - one refresh every 32 ms over 2048 rows
// - wait 160 ns after refresh pin high before selecting
// - 100 us pause with chip select high after reset
// - access cycles start at least 130 ns apart
// - read-modify-write lasts at least 180 ns
// - auto refresh requests start at least 130 ns apart
// - refresh request at least 40 ns after chip select rises
module psr_controller #(
    parameter int PAUSE_CYC  = `PSR_PAUSE_CYC,
    parameter int REFINT_CYC = `PSR_REFINT_CYC
) (
    input  wire  logic                    mclk,
    input  wire  logic                    reset,
    input  wire  logic                    reqValid,
    input  wire  psr_pkg::psr_op_e        reqOp,
    input  wire  logic [`PSR_ADDR_W-1:0]  reqAddr,
    input  wire  logic [`PSR_DATA_W-1:0]  reqWdata,
    output logic                          reqReady,
    output logic                          rspValid,
    output logic [`PSR_DATA_W-1:0]        rspRdata,
    output logic                          chipSelect_n,
    output logic                          readWrite,
    output logic                          output_gate_refresh_n,
    output logic [`PSR_ADDR_W-1:0]        addr_lines,
    input  wire  logic [`PSR_DATA_W-1:0]  data_pins_in,
    output logic [`PSR_DATA_W-1:0]        data_pins_out,
    output logic                          data_pins_oe_n
);
    import psr_pkg::*;

    localparam int CW = 32;

    typedef struct packed {
        psr_state_e                state;
        psr_op_e                   op;
        logic [CW-1:0]             cnt;
        logic [CW-1:0]             refTimer;
        logic                      refPending;
        logic                      reqReady;
        logic                      rspValid;
        logic [`PSR_DATA_W-1:0]    rdata;
        logic                      cs_n;
        logic                      rw;
        logic                      ogr_n;
        logic [`PSR_ADDR_W-1:0]    addr;
        logic [`PSR_DATA_W-1:0]    wdata;
        logic                      oe_n;
        logic [`PSR_DATA_W-1:0]    dinMeta;
        logic [`PSR_DATA_W-1:0]    din;
    } psr_state_s;

    psr_state_s cur;
    psr_state_s next_cur;

    function automatic logic [CW-1:0] cyc(input int n);
        cyc = CW'(n);
    endfunction

    // =========================================================
    // next state
    always_comb begin
        next_cur = cur;
        next_cur.rspValid = 1'b0;
        next_cur.reqReady = 1'b0;
        next_cur.dinMeta = data_pins_in;
        next_cur.din = cur.dinMeta;
        // interval timer keeps running through cycles
        if (cur.refTimer != '0) begin
            next_cur.refTimer = cur.refTimer - 1'b1;
        end else begin
            next_cur.refTimer = cyc(REFINT_CYC - 1);
            next_cur.refPending = 1'b1;
        end
        if (cur.cnt != '0) begin
            next_cur.cnt = cur.cnt - 1'b1;
        end
        unique case (cur.state)
            PSR_ST_PAUSE: begin
                // chip select stays high through power-up pause
                if (cur.cnt == '0) begin
                    next_cur.state = PSR_ST_IDLE;
                    next_cur.reqReady = !next_cur.refPending;
                end
            end
            PSR_ST_IDLE: begin
                // ready high means taken, so no request is ever lost
                if (reqValid && cur.reqReady) begin
                    next_cur.op = reqOp;
                    next_cur.addr = reqAddr;
                    next_cur.wdata = reqWdata;
                    next_cur.cs_n = 1'b0;
                    next_cur.rw = (reqOp != PSR_OP_WRITE);
                    // gate low for reads and read-modify-write
                    next_cur.ogr_n = (reqOp == PSR_OP_WRITE);
                    // drive data only in write
                    next_cur.oe_n = (reqOp != PSR_OP_WRITE);
                    next_cur.state = PSR_ST_CE;
                    next_cur.cnt = (reqOp == PSR_OP_RMW)
                        ? cyc(`PSR_RMW_CYC - `PSR_WP_CYC - 1)
                        : cyc(`PSR_CE_CYC - 1);
                end else if (cur.refPending) begin
                    // refresh wins only between cycles
                    // timer expiring in this cycle sets it again, set wins
                    next_cur.refPending = (cur.refTimer == '0);
                    next_cur.state = PSR_ST_RFSH;
                    next_cur.ogr_n = 1'b0;
                    next_cur.cnt = cyc(`PSR_FAP_CYC - 1);
                end else begin
                    // ready drops as soon as refresh falls due
                    next_cur.reqReady = !next_cur.refPending;
                end
            end
            PSR_ST_CE: begin
                if (cur.cnt == '0) begin
                    if (cur.op == PSR_OP_RMW) begin
                        // read half done, turn bus and pulse write
                        next_cur.rdata = cur.din;
                        next_cur.ogr_n = 1'b1;
                        next_cur.rw = 1'b0;
                        next_cur.oe_n = 1'b0;
                        next_cur.state = PSR_ST_RMW_WR;
                        next_cur.cnt = cyc(`PSR_WP_CYC - 1);
                    end else begin
                        // data stays driven one edge past cs rise
                        next_cur.cs_n = 1'b1;
                        next_cur.rw = 1'b1;
                        next_cur.ogr_n = 1'b1;
                        next_cur.state = PSR_ST_PRE;
                        // precharge pads cycle to trc
                        next_cur.cnt = cyc(`PSR_FC_CYC - `PSR_CE_CYC - 1);
                    end
                end
            end
            PSR_ST_RMW_WR: begin
                if (cur.cnt == '0) begin
                    next_cur.cs_n = 1'b1;
                    next_cur.rw = 1'b1;
                    next_cur.rspValid = 1'b1;
                    next_cur.state = PSR_ST_PRE;
                    next_cur.cnt = cyc(`PSR_PRE_CYC - 1);
                end
            end
            PSR_ST_PRE: begin
                next_cur.oe_n = 1'b1;
                if (cur.cnt == '0) begin
                    // synchroniser now holds the last pin sample taken while
                    // still selected; an earlier one beats the access time
                    if (cur.op == PSR_OP_READ) begin
                        next_cur.rdata = cur.din;
                        next_cur.rspValid = 1'b1;
                    end
                    // keep refresh request 40 ns clear of cs
                    next_cur.state = PSR_ST_RFD;
                    next_cur.cnt = cyc(`PSR_RFD_CYC - 1);
                end
            end
            PSR_ST_RFD: begin
                if (cur.cnt == '0) begin
                    next_cur.state = PSR_ST_IDLE;
                    next_cur.reqReady = !next_cur.refPending;
                end
            end
            PSR_ST_RFSH: begin
                // short auto pulse, internal counter picks row
                if (cur.cnt == '0) begin
                    next_cur.ogr_n = 1'b1;
                    next_cur.state = PSR_ST_RFP;
                    // tfc spacing and trfs guard both met
                    next_cur.cnt = cyc(`PSR_FRS_CYC - 1);
                end
            end
            PSR_ST_RFP: begin
                if (cur.cnt == '0) begin
                    next_cur.state = PSR_ST_IDLE;
                    next_cur.reqReady = !next_cur.refPending;
                end
            end
            default: next_cur.state = PSR_ST_IDLE;
        endcase
    end

    // =========================================================
    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur <= '0;
            cur.state <= PSR_ST_PAUSE;
            cur.op <= PSR_OP_READ;
            cur.cnt <= CW'(PAUSE_CYC - 1);
            cur.refTimer <= CW'(REFINT_CYC - 1);
            cur.cs_n <= 1'b1;
            cur.rw <= 1'b1;
            cur.ogr_n <= 1'b1;
            cur.oe_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign reqReady = cur.reqReady;
    assign rspValid = cur.rspValid;
    assign rspRdata = cur.rdata;
    assign chipSelect_n = cur.cs_n;
    assign readWrite = cur.rw;
    assign output_gate_refresh_n = cur.ogr_n;
    assign addr_lines = cur.addr;
    assign data_pins_out = cur.wdata;
    assign data_pins_oe_n = cur.oe_n;

    // =========================================================
    // assertions
    a_pause_cs_high: assert property (@(posedge mclk) disable iff (reset)
        cur.state == PSR_ST_PAUSE |-> cur.cs_n)
        else $error("chip select low during pause");
    a_refresh_cs_high: assert property (@(posedge mclk) disable iff (reset)
        !cur.cs_n |-> !(cur.state inside {PSR_ST_RFSH, PSR_ST_RFP}))
        else $error("refresh with chip select low");
    a_addr_stable: assert property (@(posedge mclk) disable iff (reset)
        !cur.cs_n && !$past(cur.cs_n) |-> $stable(cur.addr))
        else $error("address moved while selected");
    a_data_drive: assert property (@(posedge mclk) disable iff (reset)
        !cur.oe_n && !cur.cs_n |-> !cur.rw)
        else $error("data driven during read");
    a_take_on_ready: assert property (@(posedge mclk) disable iff (reset)
        reqValid && cur.reqReady |=> cur.state == PSR_ST_CE)
        else $error("request dropped while ready");
    a_cs_width: assert property (@(posedge mclk) disable iff (reset)
        $fell(cur.cs_n) |-> !cur.cs_n [*2])
        else $error("chip select pulse too short");
    a_cs_spacing: assert property (@(posedge mclk) disable iff (reset)
        $rose(cur.cs_n) |-> cur.cs_n [*2])
        else $error("precharge too short");
    a_rfd_gap: assert property (@(posedge mclk) disable iff (reset)
        $rose(cur.cs_n) |-> cur.ogr_n [*2])
        else $error("refresh too soon after chip select");
    a_frs_gap: assert property (@(posedge mclk) disable iff (reset)
        $rose(cur.ogr_n) && cur.cs_n && cur.state == PSR_ST_RFP
        |-> cur.cs_n [*4])
        else $error("chip select too soon after refresh");
    a_rmw_len: assert property (@(posedge mclk) disable iff (reset)
        $fell(cur.cs_n) && cur.op == PSR_OP_RMW |-> !cur.cs_n [*5])
        else $error("read modify write too short");

    c_read: cover property (@(posedge mclk) rspValid && cur.op == PSR_OP_READ);
    c_write: cover property (@(posedge mclk)
        rspValid == 1'b0 && $rose(cur.cs_n) && cur.op == PSR_OP_WRITE);
    c_rmw: cover property (@(posedge mclk) rspValid && cur.op == PSR_OP_RMW);
    c_refresh: cover property (@(posedge mclk) $fell(cur.ogr_n) && cur.cs_n);
endmodule
`default_nettype wire

// ===== design/psr_params.svh
// timing constants and field widths for the pseudo static ram controller
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

`define PSR_CLK_NS        40
`define PSR_ADDR_W        19
`define PSR_DATA_W        8
`define PSR_ROW_W         11
`define PSR_ROWS          2048
// times in ns unless the name gives ms or us, fast grade (-80)
`define PSR_TRC_NS        130
`define PSR_TRMW_NS       180
`define PSR_TCE_NS        80
`define PSR_TP_NS         40
`define PSR_TWP_NS        25
`define PSR_TRFD_NS       40
`define PSR_TFAP_NS       30
`define PSR_TFP_NS        30
`define PSR_TFRS_NS       160
`define PSR_TREF_MS       32
`define PSR_PAUSE_US      100
// min times round up
`define PSR_CYC(ns) (((ns) + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_CE_CYC        `PSR_CYC(`PSR_TCE_NS)
`define PSR_PRE_CYC       `PSR_CYC(`PSR_TP_NS)
`define PSR_RMW_CYC       `PSR_CYC(`PSR_TRMW_NS)
`define PSR_WP_CYC        `PSR_CYC(`PSR_TWP_NS)
`define PSR_RFD_CYC       `PSR_CYC(`PSR_TRFD_NS)
`define PSR_FAP_CYC       `PSR_CYC(`PSR_TFAP_NS)
`define PSR_FP_CYC        `PSR_CYC(`PSR_TFP_NS)
`define PSR_FC_CYC        `PSR_CYC(`PSR_TRC_NS)
`define PSR_FRS_CYC       `PSR_CYC(`PSR_TFRS_NS)
// long counts, max figures round down
`define PSR_PAUSE_CYC     ((`PSR_PAUSE_US * 1000 + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_REFINT_CYC    ((`PSR_TREF_MS * 1000000 / `PSR_ROWS) / `PSR_CLK_NS)

`endif

// ===== design/psr_pkg.sv
// types shared by the pseudo static ram controller
`default_nettype none
package psr_pkg;
    typedef enum logic [1:0] {
        PSR_OP_READ,
        PSR_OP_WRITE,
        PSR_OP_RMW
    } psr_op_e;

    typedef enum logic [3:0] {
        PSR_ST_PAUSE,
        PSR_ST_IDLE,
        PSR_ST_CE,
        PSR_ST_RMW_WR,
        PSR_ST_PRE,
        PSR_ST_RFD,
        PSR_ST_RFSH,
        PSR_ST_RFP
    } psr_state_e;
endpackage
`default_nettype wire

// ===== tb/psr_ram_model.sv
// behavioural pseudo static ram with pin timing checks
`include "psr_params.svh"
`default_nettype none
module psr_ram_model #(
    parameter int PAUSE_NS = 400,
    parameter int GAP_NS   = 2400
) (
    input  wire logic        reset,
    input  wire logic        chipSelect_n,
    input  wire logic        readWrite,
    input  wire logic        output_gate_refresh_n,
    input  wire logic [18:0] addr_lines,
    input  wire logic [7:0]  busIn,
    output logic             ramDrive,
    output logic [7:0]       ramData,
    output int               errCount,
    output int               refreshes
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // storage and timing marks
    logic [7:0]  mem [int];
    logic [18:0] lat;
    logic        wrPend = 0, rmw = 0, inRf = 0;
    longint      tRst = 0, tCsF = -999, tCsR = -999, tRfF = -999, tRfR = 0;
    initial begin
        errCount = 0;
        refreshes = 0;
    end
    always @(negedge reset) begin
        tRst = $time;
        tRfR = $time;
    end
    // ==========================================
    // access cycles
    always @(negedge chipSelect_n) begin
        #0;  // address lines of the same clock edge land first
        lat = addr_lines;
        rmw = 0;
        if ($time - tRst < PAUSE_NS) errCount++;
        if ($time - tCsF < `PSR_TRC_NS) errCount++;
        if ($time - tCsR < `PSR_TP_NS) errCount++;
        if (inRf || $time - tRfR < `PSR_TFRS_NS) errCount++;
        tCsF = $time;
    end
    always @(readWrite, chipSelect_n) begin
        if (!readWrite && !chipSelect_n) wrPend = 1;
        if (!readWrite && !chipSelect_n && $time > tCsF) rmw = 1;
    end
    // earlier rising edge of either strobe latches the data
    always @(posedge chipSelect_n or posedge readWrite) begin
        if (wrPend) mem[lat] = busIn;
        wrPend = 0;
    end
    always @(posedge chipSelect_n) begin
        if ($time - tCsF < (rmw ? `PSR_TRMW_NS : `PSR_TCE_NS))
            errCount++;
        tCsR = $time;
    end
    assign ramDrive = !chipSelect_n && !output_gate_refresh_n
                      && readWrite;
    always @* begin
        ramData = mem.exists(lat) ? mem[lat] : 8'h00;
    end
    // ==========================================
    // refresh, row comes from an internal counter
    always @(negedge output_gate_refresh_n) begin
        #1;  // let chip select of the same edge settle first
        if (chipSelect_n && !output_gate_refresh_n) begin
            inRf = 1;
            refreshes++;
            if ($time - 1 - tRfF < `PSR_TRC_NS) errCount++;
            if ($time - 1 - tCsR < `PSR_TRFD_NS) errCount++;
            if ($time - 1 - tRfR > GAP_NS) errCount++;
            tRfF = $time - 1;
        end
    end
    always @(posedge output_gate_refresh_n) begin
        if (inRf) begin
            if ($time - tRfF < `PSR_TFAP_NS || $time - tRfF >= 8000)
                errCount++;
            tRfR = $time;
        end
        inRf = 0;
    end
endmodule
`default_nettype wire

// ===== tb/pseudo_static_ram_interface_test.sv
// random and corner traffic through the controller into the ram model
`include "psr_params.svh"
`default_nettype none
module pseudo_static_ram_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    import psr_pkg::*;
    localparam int PAUSE = 10;
    logic mclk = 0, reset = 1, reqValid = 0;
    psr_op_e reqOp = PSR_OP_READ;
    logic [18:0] reqAddr = '0, addr_lines, a;
    logic [7:0] reqWdata = '0, rspRdata, data_pins_out, data_pins_in;
    logic [7:0] ramData, lastLevel = 8'h00;
    logic reqReady, rspValid, chipSelect_n, readWrite, ogr_n, oe_n, ramDrive;
    int n_fail = 0, total_checks = 0, cyc = 0, errCount, refreshes;
    logic [7:0] expMem [int];
    logic [18:0] wq [$];
    always #20 mclk = ~mclk;
    // released bus shows the inverse of its last level
    assign data_pins_in = !oe_n ? data_pins_out : ramDrive ? ramData
                          : ~lastLevel;
    always @(posedge mclk) lastLevel <= data_pins_in;
    psr_controller #(.PAUSE_CYC(PAUSE), .REFINT_CYC(40)) dut (
        .mclk(mclk), .reset(reset), .reqValid(reqValid), .reqOp(reqOp),
        .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
        .rspValid(rspValid), .rspRdata(rspRdata),
        .chipSelect_n(chipSelect_n), .readWrite(readWrite),
        .output_gate_refresh_n(ogr_n), .addr_lines(addr_lines),
        .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
        .data_pins_oe_n(oe_n));
    psr_ram_model #(.PAUSE_NS(PAUSE * 40), .GAP_NS(2400)) ram (
        .reset(reset), .chipSelect_n(chipSelect_n), .readWrite(readWrite),
        .output_gate_refresh_n(ogr_n), .addr_lines(addr_lines),
        .busIn(data_pins_in), .ramDrive(ramDrive), .ramData(ramData),
        .errCount(errCount), .refreshes(refreshes));
    // ==========================================
    // helpers
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (!oe_n && ramDrive) check(1, 0);
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic do_reset(input int hold);
        int n;
        reset <= 1;
        repeat (hold) @(posedge mclk);
        check({chipSelect_n, ogr_n, oe_n, reqReady}, 4'he);
        reset <= 0;
        n = 0;
        do begin @(posedge mclk); n++; end while (reqReady !== 1 && n < 99);
        check(n, PAUSE + 1);
    endtask
    task automatic op(input psr_op_e o, input logic [18:0] ad,
                      input logic [7:0] d);
        int n;
        reqOp <= o;
        reqAddr <= ad;
        reqWdata <= d;
        reqValid <= 1;
        n = 0;
        do begin @(posedge mclk); n++; end while (reqReady !== 1 && n < 99);
        reqValid <= 0;
        check(n < 99, 1);
        n = 0;
        do begin @(posedge mclk); n++; end while (rspValid !== 1 && n < 10);
        if (o == PSR_OP_WRITE) begin
            check(n, 10);
        end else begin
            check(n, o == PSR_OP_READ ? 5 : 6);
            check(rspRdata, expMem[ad]);
        end
        if (o != PSR_OP_READ) begin
            expMem[ad] = d;
            wq.push_back(ad);
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(20));
        do_reset(10);
        op(PSR_OP_WRITE, 19'h00000, 8'h5a);
        op(PSR_OP_WRITE, 19'h7ffff, 8'ha5);
        op(PSR_OP_READ, 19'h00000, 8'h00);
        op(PSR_OP_RMW, 19'h7ffff, 8'h3c);
        op(PSR_OP_READ, 19'h7ffff, 8'h00);
        $display("test corners done");
        for (int i = 0; i < 200; i++) begin
            a = $urandom();
            case ($urandom_range(2))
                0: op(PSR_OP_WRITE, a, $urandom());
                1: op(PSR_OP_READ, wq[$urandom_range(wq.size() - 1)], 0);
                default: op(PSR_OP_RMW, wq[$urandom_range(wq.size() - 1)],
                            $urandom());
            endcase
            if (i == 100) do_reset(2);
        end
        $display("test random done");
        check(errCount, 0);
        check(refreshes > 20, 1);
        report_and_stop();
    end
endmodule
`default_nettype wire
